//--- frt_timer.sv
// What this block does
// - 16-bit up counter clocked by prescaler, four ratios chosen in control.
// - counter overflow can raise an interrupt request.
// - overflow interrupt identifies itself as request number 19 (0x13).
// - count becomes zero on reset or on writing the clear bit.
// - live count is fed to every capture unit as time base.
// - selected edge on a pin copies the count into its data register.
// - per pin, software picks rising, falling or both edges.
// - a detected edge can raise an interrupt request.
// - overflow request can go to the automatic transfer service instead.
// - capture requests can also go to the automatic transfer service.
// - two capture units of two pins, four separate data registers.
// - reading the count register returns the current count.
// - count may be loaded only while halted; counting resumes from it.
module frt_timer
    import frt_pkg::*;
(
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // capture pins
    input  wire logic [NUM_PINS-1:0] cap_pin_in,
    // interrupt side
    output logic                     irq,
    output logic                     xfer_req,
    output logic [7:0]               ovf_irq_number
);

    // registers
    logic [4:0]             tcs_q;
    logic [4:0]             tcs_d;
    logic [CNT_W-1:0]       count_q;
    logic [CNT_W-1:0]       count_d;
    logic [11:0]            capctl_q;
    logic [11:0]            capctl_d;
    logic [IRQ_W-1:0]       stat_q;
    logic [IRQ_W-1:0]       stat_d;
    logic [IRQ_W-1:0]       mask_q;
    logic [IRQ_W-1:0]       mask_d;
    frt_bus_req_t           req_q;
    frt_bus_req_t           req_d;
    logic [31:0]            hrdata_d;

    // bus decode and write strobes
    logic                   addr_take;
    logic                   rd_take;
    logic                   wr_en;
    logic                   wr_tcs;
    logic                   wr_count;
    logic                   wr_capctl;
    logic                   wr_stat;
    logic                   wr_mask;

    // timer control
    logic                   count_clear;
    logic                   halted;
    logic                   pre_tick;
    logic                   step;
    logic                   ovf_evt;
    logic [1:0]             pre_sel;

    // event status and request routing
    logic [IRQ_W-1:0]       events;
    logic [IRQ_W-1:0]       stat_clr;
    logic [IRQ_W-1:0]       svc_sel;
    logic [IRQ_W-1:0]       pending;
    logic                   ovf_svc;
    logic [NUM_PINS-1:0]    cap_svc;
    logic                   irq_d;
    logic                   xfer_d;

    // capture side
    logic [NUM_PINS-1:0]    cap_evt;
    logic [NUM_PINS-1:0][CNT_W-1:0] cap_data;
    frt_cap_cfg_t [NUM_PINS-1:0]    cap_cfg;

    // read path
    logic [7:0]             rd_addr;
    logic [31:0]            rd_word;
    logic                   rd_is_cap;
    logic [7:0]             cap_off;
    logic [2:0]             cap_idx;
    logic                   sel_tcs;
    logic                   sel_count;
    logic                   sel_capctl;
    logic                   sel_stat;
    logic                   sel_mask;
    logic                   sel_irqnum;
    logic [31:0]            img_tcs;
    logic [31:0]            img_count;
    logic [31:0]            img_capctl;
    logic [31:0]            img_stat;
    logic [31:0]            img_mask;
    logic [31:0]            img_irqnum;
    logic [31:0]            img_cap;

    // address phase capture: word transfers only, hsize is not decoded
    assign addr_take = hsel & hready & htrans[1];
    assign req_d.addr  = haddr[7:0];
    assign req_d.write = hwrite;
    assign req_d.valid = addr_take;

    // data phase write strobes
    assign wr_en     = req_q.valid & req_q.write;
    assign wr_tcs    = wr_en & (req_q.addr == OFF_TCS);
    assign wr_count  = wr_en & (req_q.addr == OFF_COUNT);
    assign wr_capctl = wr_en & (req_q.addr == OFF_CAPCTL);
    assign wr_stat   = wr_en & (req_q.addr == OFF_STAT);
    assign wr_mask   = wr_en & (req_q.addr == OFF_MASK);

    // control fields; the clear bit is a strobe and is never stored
    assign pre_sel     = tcs_q[TCS_PRE_LSB +: 2];
    assign halted      = tcs_q[TCS_STOP_BIT];
    assign count_clear = wr_tcs & hwdata[TCS_CLR_BIT];
    assign tcs_d       = wr_tcs ? {hwdata[TCS_SVC_BIT], 1'b0,
                                   hwdata[TCS_STOP_BIT],
                                   hwdata[TCS_PRE_LSB +: 2]}
                                : tcs_q;

    // prescaler feeding the up counter
    frt_prescaler #(
        .PW      (PRE_W)
    ) u_pre (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sel     (pre_sel),
        .run     (~halted),
        .restart (count_clear),
        .tick    (pre_tick)
    );

    // up counter: clear beats load, load only while halted
    assign step    = pre_tick & ~halted;
    assign ovf_evt = step & (count_q == CNT_MAX) & ~count_clear;
    always_comb begin
        count_d = count_q;
        if (count_clear) begin
            count_d = CNT_RESET;
        end else if (wr_count && halted) begin
            count_d = hwdata[CNT_W-1:0];
        end else if (step) begin
            count_d = count_q + 1'b1;
        end
    end
    // a write while running falls through and leaves the count alone

    // capture configuration unpacked per pin
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++) begin : g_cfg
            assign cap_cfg[p].edge_sel =
                frt_edge_t'(capctl_q[CAP_EDGE_LSB + 2*p +: 2]);
            assign cap_cfg[p].svc = capctl_q[CAP_SVC_LSB + p];
        end
    endgenerate
    assign capctl_d = wr_capctl ? hwdata[11:0] : capctl_q;

    // two capture units sharing the live count
    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            frt_capture_unit #(
                .PINS     (PINS_PER_UNIT),
                .W        (CNT_W)
            ) u_cap (
                .hclk     (hclk),
                .hresetn  (hresetn),
                .pin_in   (cap_pin_in[u*PINS_PER_UNIT +: PINS_PER_UNIT]),
                .cfg      (cap_cfg[u*PINS_PER_UNIT +: PINS_PER_UNIT]),
                .count    (count_q),
                .cap_data (cap_data[u*PINS_PER_UNIT +: PINS_PER_UNIT]),
                .cap_evt  (cap_evt[u*PINS_PER_UNIT +: PINS_PER_UNIT])
            );
        end
    endgenerate

    // sticky status: a new event wins over a same-cycle write-one clear
    assign events   = {cap_evt, ovf_evt};
    assign stat_clr = wr_stat ? hwdata[IRQ_W-1:0] : '0;
    assign stat_d   = (stat_q & ~stat_clr) | events;
    assign mask_d   = wr_mask ? hwdata[IRQ_W-1:0] : mask_q;

    // route each pending source to the cpu or to the transfer service
    assign ovf_svc = tcs_q[TCS_SVC_BIT];
    assign cap_svc = capctl_q[CAP_SVC_LSB +: NUM_PINS];
    assign svc_sel = {cap_svc, ovf_svc};
    assign pending = stat_q & mask_q;
    assign irq_d   = |(pending & ~svc_sel);
    assign xfer_d  = |(pending & svc_sel);

    // read selects: one named wire per mapped register, one wire shared by the four capture registers
    assign rd_addr    = haddr[7:0];
    assign cap_off    = rd_addr - OFF_CAP0;
    assign cap_idx    = cap_off[4:2];
    assign rd_is_cap  = (rd_addr >= OFF_CAP0) &&
                        (rd_addr < OFF_IRQNUM) &&
                        (rd_addr[1:0] == 2'b00);
    assign sel_tcs    = (rd_addr == OFF_TCS);
    assign sel_count  = (rd_addr == OFF_COUNT);
    assign sel_capctl = (rd_addr == OFF_CAPCTL);
    assign sel_stat   = (rd_addr == OFF_STAT);
    assign sel_mask   = (rd_addr == OFF_MASK);
    assign sel_irqnum = (rd_addr == OFF_IRQNUM);

    // register images, zero-extended to the bus word
    assign img_tcs    = 32'(tcs_q);
    assign img_count  = 32'(count_q);
    assign img_capctl = 32'(capctl_q);
    assign img_stat   = 32'(stat_q);
    assign img_mask   = 32'(mask_q);
    assign img_irqnum = 32'(OVF_IRQ_NUM);
    assign img_cap    = 32'(cap_data[cap_idx[1:0]]);

    // and-or read mux: an unmapped offset selects nothing, reads zero
    assign rd_word  = ({32{sel_tcs}}    & img_tcs)
                    | ({32{sel_count}}  & img_count)
                    | ({32{sel_capctl}} & img_capctl)
                    | ({32{sel_stat}}   & img_stat)
                    | ({32{sel_mask}}   & img_mask)
                    | ({32{sel_irqnum}} & img_irqnum)
                    | ({32{rd_is_cap}}  & img_cap);
    assign rd_take  = addr_take & ~hwrite;
    assign hrdata_d = rd_take ? rd_word : hrdata;

    // address phase held for the data-phase write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // read data stands until the next read is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= hrdata_d;
        end
    end

    // zero wait states once out of reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // every transfer answers OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // timer control and status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tcs_q <= TCS_RESET;
        end else begin
            tcs_q <= tcs_d;
        end
    end

    // free-running count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= CNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // capture edge and service selects
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capctl_q <= CAPCTL_RESET;
        end else begin
            capctl_q <= capctl_d;
        end
    end

    // sticky event status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stat_q <= IRQ_RESET;
        end else begin
            stat_q <= stat_d;
        end
    end

    // interrupt enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= IRQ_RESET;
        end else begin
            mask_q <= mask_d;
        end
    end

    // request level toward the cpu
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_d;
        end
    end

    // request level toward the transfer service
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_req <= 1'b0;
        end else begin
            xfer_req <= xfer_d;
        end
    end

    // fixed request number of the overflow source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ovf_irq_number <= 8'h00;
        end else begin
            ovf_irq_number <= OVF_IRQ_NUM;
        end
    end

endmodule

//--- frt_pkg.sv
package frt_pkg;

    // geometry of the timer and capture block
    localparam int unsigned CNT_W         = 16;
    localparam int unsigned NUM_UNITS     = 2;
    localparam int unsigned PINS_PER_UNIT = 2;
    localparam int unsigned NUM_PINS      = NUM_UNITS * PINS_PER_UNIT;
    localparam int unsigned IRQ_W         = NUM_PINS + 1;
    localparam int unsigned PRE_W         = 8;

    // register byte offsets
    localparam logic [7:0] OFF_TCS     = 8'h00;
    localparam logic [7:0] OFF_COUNT   = 8'h04;
    localparam logic [7:0] OFF_CAPCTL  = 8'h08;
    localparam logic [7:0] OFF_STAT    = 8'h0c;
    localparam logic [7:0] OFF_MASK    = 8'h10;
    localparam logic [7:0] OFF_CAP0    = 8'h14;
    localparam logic [7:0] OFF_IRQNUM  = 8'h24;

    // timer_control_status field positions
    localparam int unsigned TCS_PRE_LSB  = 0;
    localparam int unsigned TCS_STOP_BIT = 2;
    localparam int unsigned TCS_CLR_BIT  = 3;
    localparam int unsigned TCS_SVC_BIT  = 4;

    // capture control layout: two edge bits per pin, then service bits
    localparam int unsigned CAP_EDGE_LSB = 0;
    localparam int unsigned CAP_SVC_LSB  = 8;

    // interrupt status layout
    localparam int unsigned IRQ_OVF_BIT = 0;
    localparam int unsigned IRQ_CAP_LSB = 1;

    // values after reset, the count's top value and the overflow request number
    localparam logic [15:0] CNT_RESET    = 16'h0000;
    localparam logic [15:0] CNT_MAX      = 16'hffff;
    localparam logic [4:0]  TCS_RESET    = 5'h00;
    localparam logic [11:0] CAPCTL_RESET = 12'h000;
    localparam logic [4:0]  IRQ_RESET    = 5'h00;
    localparam logic [7:0]  OVF_IRQ_NUM  = 8'h13;

    // prescaler ratios as power-of-two shifts: 2, 4, 8, 16 machine clocks
    localparam logic [2:0] PRE_SH0 = 3'h1;
    localparam logic [2:0] PRE_SH1 = 3'h2;
    localparam logic [2:0] PRE_SH2 = 3'h3;
    localparam logic [2:0] PRE_SH3 = 3'h4;

    typedef enum logic [1:0] {
        FRT_EDGE_NONE = 2'b00,
        FRT_EDGE_RISE = 2'b01,
        FRT_EDGE_FALL = 2'b10,
        FRT_EDGE_BOTH = 2'b11
    } frt_edge_t;

    typedef struct packed {
        logic      svc;
        frt_edge_t edge_sel;
    } frt_cap_cfg_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } frt_bus_req_t;

endpackage

//--- frt_prescaler.sv
module frt_prescaler
    import frt_pkg::*;
#(
    parameter int unsigned PW = PRE_W
) (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // control
    input  wire logic [1:0] sel,
    input  wire logic       run,
    input  wire logic       restart,
    // count enable toward the up counter
    output logic            tick
);

    logic [PW-1:0] div_q;
    logic [PW-1:0] div_d;
    logic [PW-1:0] low_mask;
    logic [2:0]    shift;
    logic          hit;

    // ratio select and terminal detect
    assign shift    = (sel == 2'd0) ? PRE_SH0 :
                      (sel == 2'd1) ? PRE_SH1 :
                      (sel == 2'd2) ? PRE_SH2 : PRE_SH3;
    assign low_mask = PW'((1 << shift) - 1);
    assign hit      = run & ((div_q & low_mask) == low_mask);
    assign div_d    = restart ? '0 : (run ? div_q + 1'b1 : div_q);

    // divider holds while halted, restarts with the count clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
            tick  <= 1'b0;
        end else begin
            div_q <= div_d;
            tick  <= hit & ~restart;
        end
    end

endmodule

//--- frt_capture_unit.sv
module frt_capture_unit
    import frt_pkg::*;
#(
    parameter int unsigned PINS = PINS_PER_UNIT,
    parameter int unsigned W    = CNT_W
) (
    // clock and reset
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // external capture pins, asynchronous
    input  wire logic [PINS-1:0]          pin_in,
    // per-pin configuration and time base
    input  wire frt_cap_cfg_t [PINS-1:0]  cfg,
    input  wire logic [W-1:0]             count,
    // captured values and one-cycle event pulses
    output logic [PINS-1:0][W-1:0]        cap_data,
    output logic [PINS-1:0]               cap_evt
);

    genvar i;
    generate
        for (i = 0; i < PINS; i++) begin : g_pin
            logic sync1_q;
            logic sync2_q;
            logic prev_q;
            logic rise;
            logic fall;
            logic hit;

            // edge qualification on the synchronised level
            assign rise = sync2_q & ~prev_q;
            assign fall = ~sync2_q & prev_q;
            assign hit  = (rise & cfg[i].edge_sel[0]) |
                          (fall & cfg[i].edge_sel[1]);

            // two-stage synchroniser, history, and capture latch
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1_q     <= 1'b0;
                    sync2_q     <= 1'b0;
                    prev_q      <= 1'b0;
                    cap_data[i] <= '0;
                    cap_evt[i]  <= 1'b0;
                end else begin
                    sync1_q    <= pin_in[i];
                    sync2_q    <= sync1_q;
                    prev_q     <= sync2_q;
                    cap_evt[i] <= hit;
                    if (hit) begin
                        cap_data[i] <= count;
                    end
                end
            end
        end
    endgenerate

endmodule

//--- frt_timer_assertions.sv
module frt_timer_assertions
    import frt_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus request
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    // bus answer and interrupt number
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [7:0]  ovf_irq_number
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read address phase taken at one register
    sequence s_rd(logic [7:0] a);
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
    endsequence
    a_irq_num_pin: assert property ($past(hresetn) |->
        ovf_irq_number == 8'h13) else $error("irq number pin wrong");
    a_irq_num_read: assert property (s_rd(OFF_IRQNUM) |=>
        hrdata == 32'h13) else $error("irq number read wrong");
    a_bus_ready_okay: assert property ($past(hresetn) |->
        hreadyout && !hresp) else $error("bus not ready or not okay");
    a_rdata_hold: assert property (
        !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_count_width: assert property (s_rd(OFF_COUNT) |=>
        hrdata[31:16] == 16'h0) else $error("count wider than 16 bits");
    a_cap_width: assert property (s_rd(OFF_CAP0) |=>
        hrdata[31:16] == 16'h0) else $error("capture wider than 16 bits");
    a_unmapped_zero: assert property (s_rd(8'h28) |=>
        hrdata == 32'h0) else $error("unmapped read not zero");
    a_clear_reads0: assert property (s_rd(OFF_TCS) |=>
        !hrdata[3] && hrdata[31:5] == 27'h0)
        else $error("clear bit reads back set");
endmodule

//--- frt_pin_source.sv
module frt_pin_source (
    // clock from the bench
    input wire logic       hclk,
    // levels asked for by the bench
    input wire logic [3:0] want,
    // capture pins toward the timer
    output logic [3:0]     pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins move half a cycle off the sampling edge, held whole cycles
    always @(negedge hclk) pins <= want;
endmodule

//--- frt_timer_test.sv
module frt_timer_test
    import frt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, xfer_req;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0]  htrans, m;
    logic [2:0]  hsize;
    logic [3:0]  want, pins;
    logic [7:0]  irqn;
    int          fail_count, n_checks, k, e;

    // design and pin source
    frt_timer u_frt_timer (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .cap_pin_in(pins), .irq, .xfer_req, .ovf_irq_number(irqn));
    frt_pin_source u_frt_pin_source (.hclk, .want, .pins);

    // clock
    initial hclk = 1'b0;
    always #5 hclk = ~hclk;

    // one single transfer; read data lands in d
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= v;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        d = hrdata;
    endtask

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(d, exp);
    endtask

    // wrap from fffe, expect the request on the chosen line
    task automatic ovf(input logic [31:0] run, input logic [1:0] lines);
        xfer(1'b1, OFF_TCS, 32'h4);
        xfer(1'b1, OFF_COUNT, 32'hfffe);
        xfer(1'b1, OFF_MASK, 32'h1);
        xfer(1'b1, OFF_TCS, run);
        k = 0;
        while (irq !== 1'b1 && xfer_req !== 1'b1 && k < 50) begin
            @(posedge hclk);
            k++;
        end
        chk({30'h0, irq, xfer_req}, {30'h0, lines});
        rdchk(OFF_STAT, 32'h1);
        xfer(1'b1, OFF_STAT, 32'h1);
        rdchk(OFF_STAT, 32'h0);
        chk({30'h0, irq, xfer_req}, 32'h0);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        results();
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, haddr, hwdata, htrans, want} = '0;
        hsize = 3'h2;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk({24'h0, irqn}, 32'h13);
        rdchk(OFF_IRQNUM, 32'h13);
        rdchk(OFF_STAT, 32'h0);
        rdchk(OFF_CAPCTL, 32'h0);
        rdchk(OFF_CAP0, 32'h0);
        rdchk(8'h28, 32'h0);
        $display("test reset done");
        xfer(1'b1, OFF_TCS, 32'hc);
        rdchk(OFF_COUNT, 32'h0);
        rdchk(OFF_TCS, 32'h4);
        xfer(1'b1, OFF_COUNT, 32'h1234);
        repeat (20) @(posedge hclk);
        rdchk(OFF_COUNT, 32'h1234);
        xfer(1'b1, OFF_TCS, 32'h3);
        xfer(1'b1, OFF_COUNT, 32'haaaa);
        xfer(1'b1, OFF_TCS, 32'h7);
        xfer(1'b0, OFF_COUNT, 32'h0);
        chk(32'(d >= 32'h1234 && d <= 32'h1236), 32'h1);
        $display("test load done");
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, OFF_TCS, 32'hc);
            xfer(1'b1, OFF_TCS, 32'(s));
            repeat (64) @(posedge hclk);
            xfer(1'b1, OFF_TCS, 32'(4 + s));
            xfer(1'b0, OFF_COUNT, 32'h0);
            e = 66 >> (s + 1);
            chk(32'(int'(d) >= e - 1 && int'(d) <= e + 1), 32'h1);
        end
        $display("test prescale done");
        ovf(32'h0, 2'b10);
        ovf(32'h10, 2'b01);
        $display("test overflow done");
        for (int i = 0; i < 4; i++) begin
            m = 2'(i % 3 + 1);
            xfer(1'b1, OFF_TCS, 32'h4);
            xfer(1'b1, OFF_COUNT, 32'h1000 + 32'(i));
            xfer(1'b1, OFF_MASK, 32'h0);
            xfer(1'b1, OFF_STAT, 32'h1f);
            xfer(1'b1, OFF_CAPCTL, (32'(m) << (2 * i)) |
                 (32'(i == 3) << (8 + i)));
            want[i] <= 1'b1;
            repeat (8) @(posedge hclk);
            rdchk(OFF_STAT, 32'(m[0]) << (1 + i));
            chk({31'h0, irq}, 32'h0);
            xfer(1'b1, OFF_MASK, 32'h1 << (1 + i));
            xfer(1'b1, OFF_COUNT, 32'h2000 + 32'(i));
            want[i] <= 1'b0;
            repeat (8) @(posedge hclk);
            rdchk(OFF_STAT, 32'h1 << (1 + i));
            rdchk(OFF_CAP0 + 8'(4 * i),
                  (m[1] ? 32'h2000 : 32'h1000) + 32'(i));
            chk({30'h0, irq, xfer_req}, i == 3 ? 32'h1 : 32'h2);
            $display("test capture pin %0d done", i);
        end
        xfer(1'b1, OFF_STAT, 32'h1f);
        want[0] <= 1'b1;
        repeat (8) @(posedge hclk);
        rdchk(OFF_STAT, 32'h0);
        rdchk(OFF_CAP0, 32'h1000);
        $display("test edge off done");
        results();
    end
endmodule

// checker beside the timer's ports
bind frt_timer frt_timer_assertions u_chk (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .ovf_irq_number);
